// ---- rtl/sram_ctrl_map.svh ----
// Timing and width constants for the static memory access controller
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH
`define ADDR_W 20
`define DATA_W 8
`define CLK_PERIOD_NS 20
// Memory timing in ns, as characterised for the 45 ns grade
`define READ_CYCLE_NS 45
`define ADDR_TO_DATA_NS 45
`define OUT_RELEASE_NS 18
`define WRITE_PULSE_NS 35
`define WRITE_DATA_SETUP_NS 25
`define DATA_HOLD_NS 0
// Cycle counts: least times round up
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC 4'(`CYC_UP(`ADDR_TO_DATA_NS) + 1)
`define RELEASE_CYC 4'(`CYC_UP(`OUT_RELEASE_NS))
`define WRITE_LOW_CYC 4'(`CYC_UP(`OUT_RELEASE_NS + `WRITE_DATA_SETUP_NS) + 1)
`define HOLD_CYC 4'(`CYC_UP(`DATA_HOLD_NS) + 1)
`define ONE_CYC 4'h1
`define ZERO_CYC 4'h0
`endif

// ---- rtl/sram_ctrl_pkg.sv ----
// Types for the static memory access controller
package sram_ctrl_pkg;
  typedef enum {IDLE, READ_WAIT, READ_DONE, WR_RELEASE, WR_PULSE, WR_HOLD} state_t;
endpackage

// ---- rtl/sram_pins_if.sv ----
// Memory pin bundle between sequencer and pin stage
`timescale 1ns/1ps
interface sram_pins_if;
  logic [19:0] addr;
  logic selN;
  logic sel;
  logic wrN;
  logic oeN;
  logic [7:0] dOut;
  logic dOe;
  modport seq (output addr, selN, sel, wrN, oeN, dOut, dOe);
  modport pin (input addr, selN, sel, wrN, oeN, dOut, dOe);
endinterface

// ---- rtl/sram_pin_stage.sv ----
// Registered pin drivers and two-stage read-data synchroniser
`timescale 1ns/1ps
`include "sram_ctrl_map.svh"
module sram_pin_stage (
  input wire logic coreClk, // Core clock
  input wire logic sysRst, // Synchronous reset
  sram_pins_if.pin p, // Sequencer requests
  input wire logic [`DATA_W-1:0] memDataIn, // Data pins sampled
  output logic [`DATA_W-1:0] memDataSync, // Synchronised data
  output logic [`ADDR_W-1:0] memAddr, // Address pins
  output logic primarySelectN, // Active-low select
  output logic secondarySelect, // Active-high select
  output logic writeStrobeN, // Write strobe
  output logic outputDriveN, // Output drive enable
  output logic [`DATA_W-1:0] memDataOut, // Data pins out
  output logic memDataOeN // Low while we drive data
);
  logic [`DATA_W-1:0] syncA_q, syncA_d, syncB_q, syncB_d;
  logic [`ADDR_W-1:0] addr_q, addr_d;
  logic [`DATA_W-1:0] dout_q, dout_d;
  logic selN_q, selN_d, sel_q, sel_d, wrN_q, wrN_d, oeN_q, oeN_d, doeN_q, doeN_d;

  // Next values; reset parks the memory deselected with the bus released
  always_comb begin
    syncA_d = memDataIn;
    syncB_d = syncA_q;
    addr_d = p.addr;
    dout_d = p.dOut;
    selN_d = p.selN;
    sel_d = p.sel;
    wrN_d = p.wrN;
    oeN_d = p.oeN;
    doeN_d = ~p.dOe;
    if (sysRst) begin
      selN_d = 1'b1;
      sel_d = 1'b0;
      wrN_d = 1'b1;
      oeN_d = 1'b1;
      doeN_d = 1'b1;
    end
  end

  // All pins leave from flip-flops, so no glitches reach the memory
  always_ff @(posedge coreClk) begin
    syncA_q <= syncA_d;
    syncB_q <= syncB_d;
    addr_q <= addr_d;
    dout_q <= dout_d;
    selN_q <= selN_d;
    sel_q <= sel_d;
    wrN_q <= wrN_d;
    oeN_q <= oeN_d;
    doeN_q <= doeN_d;
  end

  assign memDataSync = syncB_q;
  assign memAddr = addr_q;
  assign memDataOut = dout_q;
  assign primarySelectN = selN_q;
  assign secondarySelect = sel_q;
  assign writeStrobeN = wrN_q;
  assign outputDriveN = oeN_q;
  assign memDataOeN = doeN_q;
endmodule

// ---- rtl/sram_access_ctrl.sv ----
// Host-side controller for an asynchronous byte-wide static memory
`timescale 1ns/1ps
`include "sram_ctrl_map.svh"
// How it works
// - A write happens only while the strobe is low and both selects are active together.
// - We hold write data steady around the edge that ends the write.
// - We never drive the data pins while the memory may still be driving them.
// - The address is valid no later than the selects going active for a read.
// - A read needs strobe high, both selects active and output drive low.
// - With output drive low, the strobe stays low for release time plus data setup.
// - When deselected the memory ignores strobe and output drive; we hold selects at levels.
module sram_access_ctrl (
  input wire logic core_clk, // 50 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic reqValid, // Request strobe
  output logic reqReady, // Controller can take a request
  input wire logic reqWrite, // 1 write, 0 read
  input wire logic [`ADDR_W-1:0] reqAddr, // Byte address
  input wire logic [`DATA_W-1:0] reqWdata, // Write byte
  output logic rspValid, // Read data pulse
  output logic [`DATA_W-1:0] rspRdata, // Read byte
  output logic [`ADDR_W-1:0] memAddr, // Address pins
  output logic primarySelectN, // Active-low select pin
  output logic secondarySelect, // Active-high select pin
  output logic writeStrobeN, // Write strobe pin
  output logic outputDriveN, // Output drive enable pin
  input wire logic [`DATA_W-1:0] memDataIn, // Data pins in
  output logic [`DATA_W-1:0] memDataOut, // Data pins out
  output logic memDataOeN // Data pin enable, low drives
);
  sram_pins_if pins ();
  logic [`DATA_W-1:0] memDataSync;
  sram_ctrl_pkg::state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [`ADDR_W-1:0] addr_q, addr_d;
  logic [`DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic rspValid_q, rspValid_d;

  sram_pin_stage stage (
    .coreClk(core_clk),
    .sysRst(sys_rst),
    .p(pins),
    .memDataIn(memDataIn),
    .memDataSync(memDataSync),
    .memAddr(memAddr),
    .primarySelectN(primarySelectN),
    .secondarySelect(secondarySelect),
    .writeStrobeN(writeStrobeN),
    .outputDriveN(outputDriveN),
    .memDataOut(memDataOut),
    .memDataOeN(memDataOeN)
  );

  assign reqReady = (state_q == sram_ctrl_pkg::IDLE);

  // Sequencer next state; address latched with the request so it reaches the pins on the same edge as the selects
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rspValid_d = 1'b0;
    case (state_q)
      sram_ctrl_pkg::IDLE: begin
        if (reqValid) begin
          addr_d = reqAddr;
          wdata_d = reqWdata;
          if (reqWrite) begin
            state_d = sram_ctrl_pkg::WR_RELEASE;
            cnt_d = `RELEASE_CYC;
          end else begin
            state_d = sram_ctrl_pkg::READ_WAIT;
            cnt_d = `READ_WAIT_CYC;
          end
        end
      end
      sram_ctrl_pkg::READ_WAIT: begin
        // Extra cycles cover pin register plus two-stage data sync
        if (cnt_q == `ZERO_CYC) begin
          state_d = sram_ctrl_pkg::READ_DONE;
        end else begin
          cnt_d = cnt_q - `ONE_CYC;
        end
      end
      sram_ctrl_pkg::READ_DONE: begin
        rdata_d = memDataSync;
        rspValid_d = 1'b1;
        state_d = sram_ctrl_pkg::IDLE;
      end
      sram_ctrl_pkg::WR_RELEASE: begin
        // Output drive is high here; wait out the memory's float time
        if (cnt_q == `ZERO_CYC) begin
          state_d = sram_ctrl_pkg::WR_PULSE;
          cnt_d = `WRITE_LOW_CYC;
        end else begin
          cnt_d = cnt_q - `ONE_CYC;
        end
      end
      sram_ctrl_pkg::WR_PULSE: begin
        if (cnt_q == `ZERO_CYC) begin
          state_d = sram_ctrl_pkg::WR_HOLD;
          cnt_d = `HOLD_CYC;
        end else begin
          cnt_d = cnt_q - `ONE_CYC;
        end
      end
      sram_ctrl_pkg::WR_HOLD: begin
        if (cnt_q == `ZERO_CYC) begin
          state_d = sram_ctrl_pkg::IDLE;
        end else begin
          cnt_d = cnt_q - `ONE_CYC;
        end
      end
      default: state_d = sram_ctrl_pkg::IDLE;
    endcase
    if (sys_rst) begin
      state_d = sram_ctrl_pkg::IDLE;
      cnt_d = `ZERO_CYC;
      rspValid_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    state_q <= state_d;
    cnt_q <= cnt_d;
    addr_q <= addr_d;
    wdata_q <= wdata_d;
    rdata_q <= rdata_d;
    rspValid_q <= rspValid_d;
  end

  // Pin requests; selects drop together, never left floating
  always_comb begin
    pins.addr = addr_q;
    pins.dOut = wdata_q;
    pins.selN = 1'b1;
    pins.sel = 1'b0;
    pins.wrN = 1'b1;
    pins.oeN = 1'b1;
    pins.dOe = 1'b0;
    case (state_q)
      sram_ctrl_pkg::READ_WAIT, sram_ctrl_pkg::READ_DONE: begin
        pins.selN = 1'b0;
        pins.sel = 1'b1;
        pins.oeN = 1'b0;
      end
      sram_ctrl_pkg::WR_RELEASE: begin
        // Selected, output drive high: memory floats before we drive
        pins.selN = 1'b0;
        pins.sel = 1'b1;
      end
      sram_ctrl_pkg::WR_PULSE: begin
        pins.selN = 1'b0;
        pins.sel = 1'b1;
        pins.wrN = 1'b0;
        pins.dOe = 1'b1;
      end
      sram_ctrl_pkg::WR_HOLD: begin
        // Strobe alone ends the write; data held two more cycles
        pins.selN = 1'b0;
        pins.sel = 1'b1;
        pins.dOe = 1'b1;
      end
      default: begin
        pins.selN = 1'b1;
      end
    endcase
  end

  assign rspValid = rspValid_q;
  assign rspRdata = rdata_q;

  // Write strobe low only while both selects active
  property p_wr_sel;
    @(posedge core_clk) disable iff (sys_rst)
      !writeStrobeN |-> (!primarySelectN && secondarySelect);
  endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("strobe low while deselected");

  // Data driven only with output drive high
  property p_no_contention;
    @(posedge core_clk) disable iff (sys_rst)
      !memDataOeN |-> outputDriveN;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

  // Data stays driven and steady one cycle after the strobe rises
  property p_data_hold;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(writeStrobeN) |-> !memDataOeN && $stable(memDataOut);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data not held");

  // Address stable throughout an active select
  property p_addr_stable;
    @(posedge core_clk) disable iff (sys_rst)
      (!primarySelectN && $past(!primarySelectN)) |-> $stable(memAddr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");

  // Strobe low for at least three cycles (release plus setup)
  property p_pulse_width;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(writeStrobeN) |-> !writeStrobeN [*3];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("write pulse too short");

  // Read drive only with strobe high and selected
  property p_read_mode;
    @(posedge core_clk) disable iff (sys_rst)
      !outputDriveN |-> (writeStrobeN && !primarySelectN && secondarySelect);
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("bad read mode");

  // Selects always move together
  property p_sel_pair;
    @(posedge core_clk) disable iff (sys_rst)
      primarySelectN == !secondarySelect;
  endproperty
  a_sel_pair: assert property (p_sel_pair) else $error("selects disagree");

  // Read response follows a read request within seven cycles
  property p_read_rsp;
    @(posedge core_clk) disable iff (sys_rst)
      (reqValid && reqReady && !reqWrite) |-> ##[6:7] rspValid;
  endproperty
  a_read_rsp: assert property (p_read_rsp) else $error("read response late");
endmodule

// ---- test/sram_dev_model.sv ----
// Behavioural byte-wide static memory seen from the controller pins
`timescale 1ns/1ps
module sram_dev_model #(parameter int AccessNs = 45) (
  input wire logic [19:0] memAddr, // Address pins
  input wire logic primarySelectN, // Active-low select
  input wire logic secondarySelect, // Active-high select
  input wire logic writeStrobeN, // Write strobe
  input wire logic outputDriveN, // Output drive enable
  input wire logic [7:0] hostData, // Host data value
  input wire logic hostOeN, // Low while host drives
  output logic [7:0] busLevel, // Resolved data pins
  output logic clash // Both sides drive at once
);
  logic [7:0] mem [0:1048575];
  logic [7:0] rdData;
  logic [7:0] lastDrv = 8'h00;
  logic chosen;
  logic wrOn;
  logic devDrv;
  // Combined select and mode decode
  assign chosen = !primarySelectN && secondarySelect;
  assign wrOn = chosen && !writeStrobeN;
  assign devDrv = chosen && writeStrobeN && !outputDriveN;
  // Slow grade: data follows each address only after the access time
  assign #AccessNs rdData = mem[memAddr];
  // Byte lands at whichever edge ends the overlap
  always @(negedge wrOn) begin
    mem[memAddr] = busLevel;
  end
  // No pull on the pins, so a released bus shows the inverse of its last value
  always_comb begin
    if (devDrv) busLevel = rdData;
    else if (!hostOeN) busLevel = hostData;
    else busLevel = ~lastDrv;
  end
  always @(devDrv, hostOeN, rdData, hostData) begin
    if (devDrv || !hostOeN) lastDrv = devDrv ? rdData : hostData;
  end
  assign clash = devDrv && !hostOeN;
endmodule

// ---- test/async_sram_access_control_tb_top.sv ----
// Self-checking bench for the static memory access controller
`timescale 1ns/1ps
`include "sram_ctrl_map.svh"
module async_sram_access_control_tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [19:0] reqAddr = 20'h00000;
  logic [7:0] reqWdata = 8'h00;
  logic reqReady, rspValid, primarySelectN, secondarySelect, writeStrobeN, outputDriveN;
  logic [7:0] rspRdata, memDataIn, memDataOut;
  logic [19:0] memAddr;
  logic memDataOeN, clash;
  int fail_count = 0;
  int checks = 0;
  int n;
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  sram_access_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .rspValid(rspValid), .rspRdata(rspRdata), .memAddr(memAddr),
    .primarySelectN(primarySelectN), .secondarySelect(secondarySelect),
    .writeStrobeN(writeStrobeN), .outputDriveN(outputDriveN), .memDataIn(memDataIn),
    .memDataOut(memDataOut), .memDataOeN(memDataOeN));
  sram_dev_model mdl (.memAddr(memAddr), .primarySelectN(primarySelectN),
    .secondarySelect(secondarySelect), .writeStrobeN(writeStrobeN),
    .outputDriveN(outputDriveN), .hostData(memDataOut), .hostOeN(memDataOeN),
    .busLevel(memDataIn), .clash(clash));
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Pin watch mid-cycle, where the registered pins have settled
  always @(negedge core_clk) begin
    if (clash === 1'b1) check("bus clash", 20'h1, 20'h0);
    if (!sys_rst) check("select pair", secondarySelect, !primarySelectN);
  end
  // One request, held until the take edge
  task automatic issue(input logic wr, input logic [19:0] a, input logic [7:0] d);
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 50) check("ready timeout", 20'h1, 20'h0);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
  endtask
  task automatic readBack(input logic [19:0] a, input logic [7:0] exp);
    issue(1'b0, a, 8'h00);
    n = 0;
    while (rspValid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    // Response is visible just after the sixth edge past the take edge
    check("read latency", 20'(n), 20'h6);
    check("read data", rspRdata, exp);
  endtask
  // Strobe held for release plus setup; byte must land in the array
  task automatic writeOne(input logic [19:0] a, input logic [7:0] d);
    int low;
    low = 0;
    issue(1'b1, a, d);
    n = 0;
    while (reqReady !== 1'b1 && n < 20) begin
      if (writeStrobeN === 1'b0) low++;
      @(posedge core_clk);
      #1;
      n++;
    end
    // Pulse state also spans the cycle in which its counter sits at zero
    check("strobe low cycles", 20'(low), 20'(`WRITE_LOW_CYC + 1));
    check("write done", reqReady, 20'h1);
    check("stored byte", mdl.mem[a], d);
  endtask
  task automatic tIdle();
    check("idle pins", {primarySelectN, secondarySelect, writeStrobeN, outputDriveN,
      memDataOeN, reqReady, rspValid}, 7'h5e);
    $display("test idle done");
  endtask
  // Both ends of the address range, back to back
  task automatic tWrRd();
    writeOne(20'h00000, 8'h3c);
    writeOne(20'hfffff, 8'hc3);
    readBack(20'hfffff, 8'hc3);
    readBack(20'h00000, 8'h3c);
    $display("test write read done");
  endtask
  // A request while busy is ignored; its target holds a known byte first
  task automatic tRefuse();
    writeOne(20'h00011, 8'h00);
    issue(1'b1, 20'h00010, 8'h5a);
    @(posedge core_clk);
    #1;
    reqAddr = 20'h00011;
    reqValid = 1'b1;
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
    readBack(20'h00010, 8'h5a);
    // Looked at only once the taken write has long finished
    check("ignored write", mdl.mem[20'h00011], 8'h00);
    $display("test refuse done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    tIdle();
    tWrRd();
    tRefuse();
    conclude();
  end
  // Whole run is well under a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    $display("Watchdog expired");
    conclude();
  end
endmodule
